/* src/oaes_regs.svh */
// Register selectors, field positions, reset values and widths of the status groups.
`ifndef OAES_REGS_SVH
`define OAES_REGS_SVH

`define OAES_W 16
`define OAES_SEL_W 4
`define OAES_SEL_OP_COND 4'h0
`define OAES_SEL_OP_RISE 4'h1
`define OAES_SEL_OP_FALL 4'h2
`define OAES_SEL_OP_EVT 4'h3
`define OAES_SEL_OP_MASK 4'h4
`define OAES_SEL_ARM_COND 4'h5
`define OAES_SEL_ARM_RISE 4'h6
`define OAES_SEL_ARM_FALL 4'h7
`define OAES_SEL_ARM_EVT 4'h8
`define OAES_SEL_ARM_MASK 4'h9
`define OAES_ARM_BIT 1
`define OAES_WAIT_ARM_BIT 6
`define OAES_RISE_RST 16'hffff
`define OAES_FALL_RST 16'h0000
`define OAES_MASK_RST 16'h0000
`define OAES_EVT_RST 16'h0000

`endif

/* src/oaes_pkg.sv */
// Types shared by the operation and arm status groups.
`default_nettype none
package oaes_pkg;
	typedef logic [15:0] oaes_word_t;
	typedef enum logic [3:0] {
		OAES_IDLE = 4'h1,
		OAES_WRITE = 4'h2,
		OAES_READ = 4'h4,
		OAES_CLEAR = 4'h8
	} oaes_cmd_e;
endpackage : oaes_pkg
`default_nettype wire

/* src/oaes_edge_latch.sv */
// One transition-filtered sticky event register with its masked summary.
`timescale 1ns/1ns
`default_nettype none
`include "oaes_regs.svh"

module oaes_edge_latch #(
	parameter int W = `OAES_W
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Condition and filters
	input wire logic [W-1:0] cond_in,
	input wire logic [W-1:0] pos_in,
	input wire logic [W-1:0] neg_in,
	input wire logic [W-1:0] mask_in,
	// Clearing
	input wire logic clear_in,
	// Results
	output logic [W-1:0] event_out,
	output logic summary_out
);
	logic [W-1:0] cond_ff;
	logic [W-1:0] event_ff;
	logic [W-1:0] nxt_cond;
	logic [W-1:0] nxt_event;
	logic [W-1:0] hit;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			assign hit[i] = (cond_in[i] & ~cond_ff[i] & pos_in[i]) |
				(~cond_in[i] & cond_ff[i] & neg_in[i]);
		end
	endgenerate

	always_comb begin
		nxt_cond = cond_in;
		nxt_event = (clear_in ? W'(`OAES_EVT_RST) : event_ff) | hit;
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			cond_ff <= '0;
			event_ff <= `OAES_EVT_RST;
		end else begin
			cond_ff <= nxt_cond;
			event_ff <= nxt_event;
		end
	end

	assign event_out = event_ff;
	assign summary_out = |(event_ff & mask_in);
endmodule : oaes_edge_latch

`default_nettype wire

/* src/oaes_status.sv */
// Operation and arm event status groups with their command port.
//
// Behaviour
// - Every status register is sixteen bits.
// - Filter queries leave operation filters unchanged.
// - Operation filters preset to all ones, zeros.
// - Operation event latches on filtered condition edges.
// - Operation events stick until read, clear, reset.
// - Operation summary ORs masked event bits.
// - Mask zero blocks, mask one passes event.
// - Operation mask reads harmless, preset clears it.
// - Arm condition B1 follows sequence summary input.
// - Arm filters act on bit B1 only.
// - Arm B1 sets on selected edge.
// - Arm filters preset to all ones, zeros.
// - Arm events stick; read, clear, reset clear.
// - Arm summary drives waiting-for-arm condition.
// - Arm mask B1 gates waiting-for-arm.
// - Arm mask clears only by reset, write.
// - Waiting-for-arm sits at operation condition B6.
`timescale 1ns/1ns
`default_nettype none
`include "oaes_regs.svh"

module oaes_status (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Command port
	input wire logic [3:0] cmd_in,
	input wire logic [`OAES_SEL_W-1:0] sel_in,
	input wire logic [15:0] wdata_in,
	input wire logic preset_in,
	// Condition sources
	input wire logic [15:0] op_cond_in,
	input wire logic seq_summary_in,
	// Results
	output logic [15:0] rdata_out,
	output logic rvalid_out,
	output logic operation_summary_bit_out,
	output logic [15:0] op_cond_out
);
	oaes_pkg::oaes_word_t op_rise_ff;
	oaes_pkg::oaes_word_t op_fall_ff;
	oaes_pkg::oaes_word_t op_mask_ff;
	oaes_pkg::oaes_word_t nxt_op_rise;
	oaes_pkg::oaes_word_t nxt_op_fall;
	oaes_pkg::oaes_word_t nxt_op_mask;
	oaes_pkg::oaes_word_t arm_rise_ff;
	oaes_pkg::oaes_word_t arm_fall_ff;
	oaes_pkg::oaes_word_t arm_mask_ff;
	oaes_pkg::oaes_word_t nxt_arm_rise;
	oaes_pkg::oaes_word_t nxt_arm_fall;
	oaes_pkg::oaes_word_t nxt_arm_mask;
	oaes_pkg::oaes_word_t rdata_ff;
	oaes_pkg::oaes_word_t nxt_rdata;
	logic rvalid_ff;
	logic nxt_rvalid;
	oaes_pkg::oaes_word_t op_event;
	oaes_pkg::oaes_word_t arm_event;
	oaes_pkg::oaes_word_t arm_cond;
	oaes_pkg::oaes_word_t op_cond_full;
	oaes_pkg::oaes_word_t arm_rise_eff;
	oaes_pkg::oaes_word_t arm_fall_eff;
	logic arm_summary;
	logic op_summary;
	oaes_pkg::oaes_cmd_e cmd_kind;
	logic wr;
	logic rd;
	logic clr;
	logic op_evt_clr;
	logic arm_evt_clr;

	function automatic logic sel_is(input logic [3:0] s, input logic [3:0] want);
		sel_is = (s == want);
	endfunction : sel_is

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	always_comb begin
		case (cmd_in)
			oaes_pkg::OAES_WRITE: cmd_kind = oaes_pkg::OAES_WRITE;
			oaes_pkg::OAES_READ: cmd_kind = oaes_pkg::OAES_READ;
			oaes_pkg::OAES_CLEAR: cmd_kind = oaes_pkg::OAES_CLEAR;
			default: cmd_kind = oaes_pkg::OAES_IDLE;
		endcase
	end

	assign wr = (cmd_kind == oaes_pkg::OAES_WRITE);
	assign rd = (cmd_kind == oaes_pkg::OAES_READ);
	assign clr = (cmd_kind == oaes_pkg::OAES_CLEAR);

	// ------------------------------------------------------------
	// Condition words
	// ------------------------------------------------------------
	// Arm condition B1 tracking.
	always_comb begin
		arm_cond = '0;
		arm_cond[`OAES_ARM_BIT] = seq_summary_in;
	end

	always_comb begin
		op_cond_full = op_cond_in;
		op_cond_full[`OAES_WAIT_ARM_BIT] = arm_summary;
	end

	always_comb begin
		arm_rise_eff = '0;
		arm_fall_eff = '0;
		arm_rise_eff[`OAES_ARM_BIT] = arm_rise_ff[`OAES_ARM_BIT];
		arm_fall_eff[`OAES_ARM_BIT] = arm_fall_ff[`OAES_ARM_BIT];
	end

	// ------------------------------------------------------------
	// Operation transition filters
	// ------------------------------------------------------------
	always_comb begin
		nxt_op_rise = op_rise_ff;
		nxt_op_fall = op_fall_ff;
		if (wr && sel_is(sel_in, `OAES_SEL_OP_RISE)) begin
			nxt_op_rise = wdata_in;
		end
		if (wr && sel_is(sel_in, `OAES_SEL_OP_FALL)) begin
			nxt_op_fall = wdata_in;
		end
		if (preset_in) begin
			nxt_op_rise = `OAES_RISE_RST;
			nxt_op_fall = `OAES_FALL_RST;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			op_rise_ff <= `OAES_RISE_RST;
			op_fall_ff <= `OAES_FALL_RST;
		end else begin
			op_rise_ff <= nxt_op_rise;
			op_fall_ff <= nxt_op_fall;
		end
	end

	// ------------------------------------------------------------
	// Operation enable mask
	// ------------------------------------------------------------
	always_comb begin
		nxt_op_mask = op_mask_ff;
		if (wr && sel_is(sel_in, `OAES_SEL_OP_MASK)) begin
			nxt_op_mask = wdata_in;
		end
		if (preset_in) begin
			nxt_op_mask = `OAES_MASK_RST;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			op_mask_ff <= `OAES_MASK_RST;
		end else begin
			op_mask_ff <= nxt_op_mask;
		end
	end

	// ------------------------------------------------------------
	// Arm transition filters
	// ------------------------------------------------------------
	always_comb begin
		nxt_arm_rise = arm_rise_ff;
		nxt_arm_fall = arm_fall_ff;
		if (wr && sel_is(sel_in, `OAES_SEL_ARM_RISE)) begin
			nxt_arm_rise = wdata_in;
		end
		if (wr && sel_is(sel_in, `OAES_SEL_ARM_FALL)) begin
			nxt_arm_fall = wdata_in;
		end
		if (preset_in) begin
			nxt_arm_rise = `OAES_RISE_RST;
			nxt_arm_fall = `OAES_FALL_RST;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			arm_rise_ff <= `OAES_RISE_RST;
			arm_fall_ff <= `OAES_FALL_RST;
		end else begin
			arm_rise_ff <= nxt_arm_rise;
			arm_fall_ff <= nxt_arm_fall;
		end
	end

	// ------------------------------------------------------------
	// Arm enable mask
	// ------------------------------------------------------------
	always_comb begin
		nxt_arm_mask = arm_mask_ff;
		// Arm mask changes by write only.
		if (wr && sel_is(sel_in, `OAES_SEL_ARM_MASK)) begin
			nxt_arm_mask = wdata_in;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			arm_mask_ff <= `OAES_MASK_RST;
		end else begin
			arm_mask_ff <= nxt_arm_mask;
		end
	end

	// ------------------------------------------------------------
	// Event groups
	// ------------------------------------------------------------
	// Read or clear-status empties.
	assign op_evt_clr = clr | (rd & sel_is(sel_in, `OAES_SEL_OP_EVT));
	assign arm_evt_clr = clr | (rd & sel_is(sel_in, `OAES_SEL_ARM_EVT));

	oaes_edge_latch #(.W(16)) u_arm (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.cond_in(arm_cond),
		.pos_in(arm_rise_eff),
		.neg_in(arm_fall_eff),
		.mask_in(arm_mask_ff),
		.clear_in(arm_evt_clr),
		.event_out(arm_event),
		.summary_out(arm_summary)
	);

	oaes_edge_latch #(.W(16)) u_op (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.cond_in(op_cond_full),
		.pos_in(op_rise_ff),
		.neg_in(op_fall_ff),
		.mask_in(op_mask_ff),
		.clear_in(op_evt_clr),
		.event_out(op_event),
		.summary_out(op_summary)
	);

	// ------------------------------------------------------------
	// Summary outputs
	// ------------------------------------------------------------
	// Operation summary output.
	assign operation_summary_bit_out = op_summary;
	assign op_cond_out = op_cond_full;

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always_comb begin
		nxt_rvalid = rd;
		nxt_rdata = rdata_ff;
		if (rd) begin
			case (sel_in)
				`OAES_SEL_OP_COND: nxt_rdata = op_cond_full;
				`OAES_SEL_OP_RISE: nxt_rdata = op_rise_ff;
				`OAES_SEL_OP_FALL: nxt_rdata = op_fall_ff;
				`OAES_SEL_OP_EVT: nxt_rdata = op_event;
				`OAES_SEL_OP_MASK: nxt_rdata = op_mask_ff;
				`OAES_SEL_ARM_COND: nxt_rdata = arm_cond;
				`OAES_SEL_ARM_RISE: nxt_rdata = arm_rise_ff;
				`OAES_SEL_ARM_FALL: nxt_rdata = arm_fall_ff;
				`OAES_SEL_ARM_EVT: nxt_rdata = arm_event;
				`OAES_SEL_ARM_MASK: nxt_rdata = arm_mask_ff;
				default: nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rdata_ff <= '0;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	// ------------------------------------------------------------
	// Output ports
	// ------------------------------------------------------------
	assign rdata_out = rdata_ff;
	assign rvalid_out = rvalid_ff;
endmodule : oaes_status

`default_nettype wire

/* tb/oaes_checker.sv */
// Port checks for the operation and arm status groups.
`timescale 1ns/1ns
`default_nettype none

module oaes_checker (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Commands and sources
	input wire logic [3:0] cmd_in,
	input wire logic preset_in,
	input wire logic [15:0] op_cond_in,
	input wire logic seq_summary_in,
	// Results
	input wire logic operation_summary_bit_out,
	input wire logic [15:0] op_cond_out
);
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	AST_OPSUM_HOLD: assert property (operation_summary_bit_out && cmd_in == 4'h1 && !preset_in
		|=> operation_summary_bit_out) else $error("summary dropped while idle");
	AST_OPSUM_CAUSE: assert property ($rose(operation_summary_bit_out) |->
		$past(cmd_in) == 4'h2 || $past(op_cond_out) != $past(op_cond_out, 2) ||
		$past(op_cond_out, 2) != $past(op_cond_out, 3)) else $error("summary rose unprompted");
	AST_OPSUM_CLS: assert property (cmd_in == 4'h8 && $stable(op_cond_out) &&
		$past(op_cond_out) == $past(op_cond_out, 2) |=> !operation_summary_bit_out)
		else $error("summary kept after clear");
	AST_OPSUM_PRESET: assert property (preset_in |=> !operation_summary_bit_out)
		else $error("summary kept after preset");
	AST_WAIT_HOLD: assert property (op_cond_out[6] && cmd_in == 4'h1 |=> op_cond_out[6])
		else $error("arm summary dropped while idle");
	AST_WAIT_CAUSE: assert property ($rose(op_cond_out[6]) |-> $past(cmd_in) == 4'h2 ||
		$past(seq_summary_in) != $past(seq_summary_in, 2) ||
		$past(seq_summary_in, 2) != $past(seq_summary_in, 3)) else $error("arm summary rose");
	AST_WAIT_CLS: assert property (cmd_in == 4'h8 && $stable(seq_summary_in) |=>
		!op_cond_out[6]) else $error("arm summary kept after clear");
	AST_WAIT_PRESET: assert property (preset_in && cmd_in == 4'h1 && op_cond_out[6] |=>
		op_cond_out[6]) else $error("preset touched arm mask");
	AST_WAIT_BIT: assert property ({op_cond_out[15:7], op_cond_out[5:0]} ==
		{op_cond_in[15:7], op_cond_in[5:0]}) else $error("condition bits altered");
endmodule : oaes_checker

bind oaes_status oaes_checker i_chk (.mclk_in(mclk_in), .rst_in(rst_in), .cmd_in(cmd_in),
	.preset_in(preset_in), .op_cond_in(op_cond_in), .seq_summary_in(seq_summary_in),
	.operation_summary_bit_out(operation_summary_bit_out), .op_cond_out(op_cond_out));

`default_nettype wire

/* tb/oaes_host.sv */
// Host model issuing status commands to the block.
`timescale 1ns/1ns
`default_nettype none

module oaes_host (
	// Clock and answers
	input wire logic mclk_in,
	input wire logic [15:0] rdata_in,
	input wire logic rvalid_in,
	// Commands
	output logic [3:0] cmd_out,
	output logic [3:0] sel_out,
	output logic [15:0] wdata_out,
	output logic preset_out
);
	initial begin
		cmd_out = 4'h1;
		sel_out = 4'h0;
		wdata_out = 16'h0000;
		preset_out = 1'b0;
	end

	task automatic xfer(input logic [3:0] c, input logic [3:0] s, input logic [15:0] d,
		output logic [15:0] q, output logic v);
		@(posedge mclk_in);
		cmd_out <= c;
		sel_out <= s;
		wdata_out <= d;
		@(posedge mclk_in);
		cmd_out <= 4'h1;
		sel_out <= ~s;
		wdata_out <= ~d;
		@(negedge mclk_in);
		q = rdata_in;
		v = rvalid_in;
	endtask : xfer

	task automatic preset();
		@(posedge mclk_in);
		preset_out <= 1'b1;
		@(posedge mclk_in);
		preset_out <= 1'b0;
		@(negedge mclk_in);
	endtask : preset
endmodule : oaes_host

`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the operation and arm status groups.
`timescale 1ns/1ns
`default_nettype none

module tb;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [3:0] cmd;
	logic [3:0] sel;
	logic [15:0] wdata;
	logic preset;
	logic [15:0] op_cond = 16'h0000;
	logic seq = 1'b0;
	logic [15:0] rdata;
	logic rvalid;
	logic op_sum;
	logic [15:0] cond_out;
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [19:0] tbl [9] = '{20'h1ffff, 20'h20000, 20'h40000, 20'h6ffff, 20'h70000,
		20'h90000, 20'h30000, 20'h80000, 20'ha0000};

	always #4 mclk_in = ~mclk_in;

	oaes_status i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .cmd_in(cmd), .sel_in(sel),
		.wdata_in(wdata), .preset_in(preset), .op_cond_in(op_cond), .seq_summary_in(seq),
		.rdata_out(rdata), .rvalid_out(rvalid), .operation_summary_bit_out(op_sum),
		.op_cond_out(cond_out));
	oaes_host i_host (.mclk_in(mclk_in), .rdata_in(rdata), .rvalid_in(rvalid), .cmd_out(cmd),
		.sel_out(sel), .wdata_out(wdata), .preset_out(preset));

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic put(input logic [3:0] c, input logic [3:0] s, input logic [15:0] d);
		logic [15:0] q;
		logic v;
		i_host.xfer(c, s, d, q, v);
	endtask : put

	task automatic rd(input logic [3:0] s, input logic [15:0] e);
		logic [15:0] q;
		logic v;
		i_host.xfer(4'h4, s, 16'h0000, q, v);
		chk(16'(v), 16'h0001);
		chk(q, e);
		@(negedge mclk_in);
		chk(16'(rvalid), 16'h0000);
	endtask : rd

	task automatic cond(input logic [15:0] c, input logic s);
		@(posedge mclk_in);
		op_cond <= c;
		seq <= s;
		repeat (4) @(posedge mclk_in);
		@(negedge mclk_in);
	endtask : cond

	task automatic t_defaults();
		for (int i = 0; i < 9; i++) begin
			rd(tbl[i][19:16], tbl[i][15:0]);
		end
	endtask : t_defaults

	task automatic t_filter();
		put(4'h2, 4'h1, 16'h0000);
		put(4'h2, 4'h2, 16'h0008);
		cond(16'h0008, 1'b0);
		rd(4'h3, 16'h0000);
		cond(16'h0000, 1'b0);
		rd(4'h3, 16'h0008);
		rd(4'h3, 16'h0000);
		rd(4'h1, 16'h0000);
		rd(4'h2, 16'h0008);
		rd(4'h2, 16'h0008);
		i_host.preset();
		rd(4'h1, 16'hffff);
		rd(4'h2, 16'h0000);
	endtask : t_filter

	task automatic t_mask();
		put(4'h2, 4'h4, 16'h0020);
		cond(16'h0020, 1'b0);
		chk(16'(op_sum), 16'h0001);
		put(4'h2, 4'h4, 16'h0010);
		chk(16'(op_sum), 16'h0000);
		put(4'h2, 4'h4, 16'h0020);
		chk(16'(op_sum), 16'h0001);
		put(4'h8, 4'h0, 16'h0000);
		chk(16'(op_sum), 16'h0000);
		rd(4'h3, 16'h0000);
	endtask : t_mask

	task automatic t_arm();
		put(4'h2, 4'h9, 16'h0002);
		cond(16'h0020, 1'b1);
		chk(cond_out, 16'h0060);
		rd(4'h3, 16'h0040);
		i_host.preset();
		chk(16'(cond_out[6]), 16'h0001);
		rd(4'h9, 16'h0002);
		rd(4'h5, 16'h0002);
		rd(4'h8, 16'h0002);
		chk(16'(cond_out[6]), 16'h0000);
		put(4'h2, 4'h6, 16'h0000);
		put(4'h2, 4'h7, 16'hffff);
		cond(16'h0020, 1'b0);
		rd(4'h8, 16'h0002);
		cond(16'h0020, 1'b1);
		rd(4'h8, 16'h0000);
		cond(16'h0020, 1'b0);
		put(4'h8, 4'h0, 16'h0000);
		chk(16'(cond_out[6]), 16'h0000);
	endtask : t_arm

	always @(posedge mclk_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			test_done();
		end
	end

	initial begin
		repeat (12) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_defaults();
		t_filter();
		t_mask();
		t_arm();
		test_done();
	end
endmodule : tb

`default_nettype wire
